// >>> include/tap_consts.vh
// constants of the memory test access port
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
`define TAP_IR_W        3
`define TAP_ID_W        32
`define TAP_IR_IDCODE   3'h1
`define TAP_IR_BYPASS   3'h7
`define TAP_IR_CAPTURE  3'h1
// arbitrary id value
`define TAP_ID_VALUE    32'h12345001
`define TAP_PIN_IDLE    1'h1
`define TAP_TCK_IDLE    1'h0
`define TAP_RST_PULSES  5
`endif

// >>> rtl/tap_port.v
// test access port controller, instruction, bypass and id registers
`timescale 1ns/1ps
`include "tap_consts.vh"
module tap_port (
  input  wire CORE_CLK,
  input  wire RST_N,
  input  wire TCK,
  input  wire TMS,
  input  wire TMS_OE_N,
  input  wire TDI,
  input  wire TDI_OE_N,
  output wire TDO_O,
  output wire TDO_OE_N,
  output wire TAP_RESET,
  output wire [2:0] TAP_IR
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHD = 16'h0010;
  localparam [15:0] S_E1D = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHI = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2I = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;
  // ----------------------------------------
  // input sampling
  // ----------------------------------------
  wire tck_s;
  wire tms_pin_s;
  wire tms_oe_n_s;
  wire tdi_pin_s;
  wire tdi_oe_n_s;
  tap_sync #(.RST_VAL(`TAP_TCK_IDLE)) u_tck (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .D     (TCK),
    .Q     (tck_s)
  );
  tap_sync #(.RST_VAL(`TAP_PIN_IDLE)) u_tms (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .D     (TMS),
    .Q     (tms_pin_s)
  );
  tap_sync #(.RST_VAL(`TAP_PIN_IDLE)) u_tms_oe (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .D     (TMS_OE_N),
    .Q     (tms_oe_n_s)
  );
  tap_sync #(.RST_VAL(`TAP_PIN_IDLE)) u_tdi (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .D     (TDI),
    .Q     (tdi_pin_s)
  );
  tap_sync #(.RST_VAL(`TAP_PIN_IDLE)) u_tdi_oe (
    .CLK   (CORE_CLK),
    .RST_N (RST_N),
    .D     (TDI_OE_N),
    .Q     (tdi_oe_n_s)
  );
  // undriven pins read high
  wire tms_s = tms_oe_n_s | tms_pin_s;
  wire tdi_s = tdi_oe_n_s | tdi_pin_s;
  reg  tck_q;
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tck_q <= `TAP_TCK_IDLE;
    end else begin
      tck_q <= tck_s;
    end
  end
  wire rise = tck_s & ~tck_q;
  wire fall = ~tck_s & tck_q;
  // ----------------------------------------
  // controller
  // ----------------------------------------
  reg  [15:0] st_q;
  reg  [15:0] st_d;
  always @* begin
    case (st_q)
      S_TLR:   st_d = tms_s ? S_TLR : S_RTI;
      S_RTI:   st_d = tms_s ? S_SDR : S_RTI;
      S_SDR:   st_d = tms_s ? S_SIR : S_CDR;
      S_CDR:   st_d = tms_s ? S_E1D : S_SHD;
      S_SHD:   st_d = tms_s ? S_E1D : S_SHD;
      S_E1D:   st_d = tms_s ? S_UDR : S_PDR;
      S_PDR:   st_d = tms_s ? S_E2D : S_PDR;
      S_E2D:   st_d = tms_s ? S_UDR : S_SHD;
      S_UDR:   st_d = tms_s ? S_SDR : S_RTI;
      S_SIR:   st_d = tms_s ? S_TLR : S_CIR;
      S_CIR:   st_d = tms_s ? S_E1I : S_SHI;
      S_SHI:   st_d = tms_s ? S_E1I : S_SHI;
      S_E1I:   st_d = tms_s ? S_UIR : S_PIR;
      S_PIR:   st_d = tms_s ? S_E2I : S_PIR;
      S_E2I:   st_d = tms_s ? S_UIR : S_SHI;
      S_UIR:   st_d = tms_s ? S_SDR : S_RTI;
      default: st_d = S_TLR;
    endcase
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [2:0]  ir_sh_q;
  reg  [2:0]  ir_q;
  reg         byp_q;
  reg  [31:0] id_q;
  wire        sel_id = (ir_q == `TAP_IR_IDCODE);
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_q    <= S_TLR;
      ir_sh_q <= `TAP_IR_IDCODE;
      ir_q    <= `TAP_IR_IDCODE;
      byp_q   <= 1'h0;
    end else if (rise) begin
      st_q <= st_d;
      if (st_d == S_TLR) begin
        ir_q <= `TAP_IR_IDCODE;
      end
      if (st_q == S_CIR) begin
        ir_sh_q <= {ir_q[2], 2'h1};
      end else if (st_q == S_SHI) begin
        ir_sh_q <= {tdi_s, ir_sh_q[2:1]};
      end
      if (st_q == S_UIR) begin
        ir_q <= ir_sh_q;
      end
      if (st_q == S_CDR) begin
        byp_q <= 1'h0;
      end else if ((st_q == S_SHD) && !sel_id) begin
        byp_q <= tdi_s;
      end
    end
  end
  // ----------------------------------------
  // identification register, one cell a bit
  // ----------------------------------------
  wire [31:0] id_val = `TAP_ID_VALUE;
  wire        id_cap = rise & (st_q == S_CDR) & sel_id;
  wire        id_sh  = rise & (st_q == S_SHD) & sel_id;
  wire [31:0] id_d;
  genvar      gi;
  generate
    for (gi = 0; gi < `TAP_ID_W; gi = gi + 1) begin : g_id
      wire in_bit;
      if (gi == `TAP_ID_W - 1) begin : g_top
        assign in_bit = tdi_s;
      end else begin : g_mid
        assign in_bit = id_q[gi + 1];
      end
      assign id_d[gi] = id_cap ? id_val[gi] : (id_sh ? in_bit : id_q[gi]);
    end
  endgenerate
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      id_q <= `TAP_ID_VALUE;
    end else begin
      id_q <= id_d;
    end
  end
  // ----------------------------------------
  // path select
  // ----------------------------------------
  reg tdo_d;
  reg tdo_oe_n_d;
  always @* begin
    tdo_oe_n_d = ~((st_q == S_SHD) | (st_q == S_SHI));
    if (st_q == S_SHI) begin
      tdo_d = ir_sh_q[0];
    end else if (sel_id) begin
      tdo_d = id_q[0];
    end else begin
      tdo_d = byp_q;
    end
  end
  // ----------------------------------------
  // output on falling edge
  // ----------------------------------------
  reg tdo_q;
  reg tdo_oe_n_q;
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tdo_q      <= 1'h1;
      tdo_oe_n_q <= 1'h1;
    end else if (fall) begin
      tdo_q      <= tdo_d;
      tdo_oe_n_q <= tdo_oe_n_d;
    end
  end
  assign TDO_O     = tdo_q;
  assign TDO_OE_N  = tdo_oe_n_q;
  assign TAP_RESET = st_q[0];
  assign TAP_IR    = ir_q;
endmodule // tap_port

// >>> rtl/tap_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tap_sync #(
  parameter RST_VAL = 1'h1
) (
  input  wire CLK,
  input  wire RST_N,
  input  wire D,
  output wire Q
);
  reg meta_q;
  reg sync_q;
  always @(posedge CLK) begin
    if (!RST_N) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= D;
      sync_q <= meta_q;
    end
  end
  assign Q = sync_q;
endmodule // tap_sync

// >>> tb/tap_ctl_model.sv
// test controller model
`timescale 1ns/1ps
module tap_ctl_model (
  input wire TDO_O,
  output reg TCK = 0,
  output reg TMS = 1,
  output reg TMS_OE_N = 0,
  output reg TDI = 0,
  output reg TDI_OE_N = 0
);
  // fl[0] floats tms, fl[1] floats tdi, driving inverse of pull-up
  task shift(input int n, input logic [31:0] tv, dv, input logic [1:0] fl, output logic [31:0] q);
    q = 0;
    for (int i = 0; i < n; i++) begin
      TMS = fl[0] ? 1'b0 : tv[i];
      TDI = fl[1] ? 1'b0 : dv[i];
      TMS_OE_N = fl[0];
      TDI_OE_N = fl[1];
      #100 TCK = 1;
      q = {TDO_O, q[31:1]};
      #100 TCK = 0;
    end
  endtask
endmodule // tap_ctl_model

// >>> tb/tap_port_chk.sv
// pin timing checker of the test port
`timescale 1ns/1ps
module tap_port_chk (
  input wire       CORE_CLK,
  input wire       RST_N,
  input wire       TCK,
  input wire       TDO_O,
  input wire       TDO_OE_N,
  input wire       TAP_RESET,
  input wire [2:0] TAP_IR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_rst; $rose(RST_N) |-> TAP_RESET && TDO_OE_N && TAP_IR == 3'h1; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_tdo; $changed(TDO_O) |-> !TCK; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo off fall");
  property p_oe; $changed(TDO_OE_N) |-> !TCK; endproperty
  a_oe: assert property (p_oe) else $error("oe off fall");
  property p_tlr_oe; TAP_RESET |-> TDO_OE_N; endproperty
  a_tlr_oe: assert property (p_tlr_oe) else $error("tdo in reset");
  property p_tlr_ir; TAP_RESET |=> TAP_IR == 3'h1; endproperty
  a_tlr_ir: assert property (p_tlr_ir) else $error("ir in reset");
  property p_st; $changed(TAP_RESET) |-> TCK; endproperty
  a_st: assert property (p_st) else $error("state off rise");
  property p_qs; $stable(TCK)[*8] |-> $stable(TAP_RESET) && $stable(TAP_IR); endproperty
  a_qs: assert property (p_qs) else $error("state moved");
  property p_qo; $stable(TCK)[*8] |-> $stable(TDO_O) && $stable(TDO_OE_N); endproperty
  a_qo: assert property (p_qo) else $error("tdo moved");
endmodule // tap_port_chk
bind tap_port tap_port_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .TCK(TCK), .TDO_O(TDO_O),
  .TDO_OE_N(TDO_OE_N), .TAP_RESET(TAP_RESET), .TAP_IR(TAP_IR));

// >>> tb/tb.sv
// testbench of the test port
`timescale 1ns/1ps
`include "tap_consts.vh"
module tb;
  reg clk = 0;
  reg rst_n = 0;
  wire tck, tms, tms_oe_n, tdi, tdi_oe_n, tdo_o, tdo_oe_n, tap_reset;
  wire [2:0] tap_ir;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] q;
  initial forever #12.5 clk = ~clk;
  tap_port DUT (.CORE_CLK(clk), .RST_N(rst_n), .TCK(tck), .TMS(tms), .TMS_OE_N(tms_oe_n), .TDI(tdi),
    .TDI_OE_N(tdi_oe_n), .TDO_O(tdo_o), .TDO_OE_N(tdo_oe_n), .TAP_RESET(tap_reset), .TAP_IR(tap_ir));
  tap_ctl_model u_ctl (.TDO_O(tdo_o), .TCK(tck), .TMS(tms), .TMS_OE_N(tms_oe_n), .TDI(tdi), .TDI_OE_N(tdi_oe_n));
  task chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_sim;
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_id;
    u_ctl.shift(4, 4'h2, 0, 0, q);
    #100 chk("oe", 0, tdo_oe_n);
    u_ctl.shift(32, 32'h80000000, 0, 0, q);
    chk("id", `TAP_ID_VALUE, q);
    #100 chk("oe", 1, tdo_oe_n);
  endtask
  task t_byp;
    u_ctl.shift(5, 5'h07, 0, 0, q);
    u_ctl.shift(3, 3'h4, 3'h7, 0, q);
    chk("ircap", 3'h1, q[31:29]);
    u_ctl.shift(5, 5'h05, 0, 0, q);
    chk("ir", `TAP_IR_BYPASS, tap_ir);
    u_ctl.shift(4, 0, 0, 2'h2, q);
    chk("byp", 4'hE, q[31:28]);
  endtask
  task t_tlr;
    u_ctl.shift(5, 0, 0, 2'h1, q);
    #100 chk("tlr", 1, tap_reset);
    chk("ir", `TAP_IR_IDCODE, tap_ir);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    repeat (20) @(posedge clk);
    chk("rst", 1, tap_reset);
    chk("rst_oe", 1, tdo_oe_n);
    t_id;
    t_byp;
    t_tlr;
    end_sim;
  end
endmodule // tb
